// ### rtl/srxsh_pkg.sv
// Package: constants and carriers for the receive setting handshake block
package srxsh_pkg;
  // ==========================================================
  // Register word addresses
  localparam logic [15:0] ADDR_COUNT_CH1  = 16'h00A4;
  localparam logic [15:0] ADDR_CODE_CH1   = 16'h00A5;
  localparam logic [15:0] ADDR_COUNT_CH2  = 16'h0144;
  localparam logic [15:0] ADDR_CODE_CH2   = 16'h0145;
  localparam logic [15:0] ADDR_RESULT_CH1 = 16'h0258;
  localparam logic [15:0] ADDR_RESULT_CH2 = 16'h0268;
  // ==========================================================
  // Reset values and code limits
  localparam logic [15:0] COUNT_RESET     = 16'h01FF;
  localparam logic [15:0] CODE_RESET      = 16'h0D0A;
  localparam logic [15:0] CODE_NONE       = 16'hFFFF;
  localparam logic [15:0] CODE_MAX        = 16'h00FF;
  localparam logic [15:0] RESULT_RESET    = 16'h0000;
  // ==========================================================
  // Carrier of one frame event from the receive engine
  typedef struct packed {
    logic        done;    // Frame finished this cycle
    logic        error;   // Frame finished with error
    logic [15:0] code;    // Error code when error
  } srxsh_event_type;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [15:0] wdata;
  } srxsh_bus_type;

  typedef enum logic [1:0] {
    SRXSH_IDLE,
    SRXSH_REQ,
    SRXSH_ERR
  } srxsh_state_type;
endpackage : srxsh_pkg

// ### rtl/srxsh_top.sv
// Receive setting registers and read handshake for two serial channels
`timescale 1ns/1ps

// ==========================================================
// One channel: settings, result word and handshake
module srxsh_chan (
  input  wire logic                      clk_in,
  input  wire logic                      rst_in,
  input  wire logic                      started_in,
  input  wire logic                      wr_count_in,
  input  wire logic                      wr_code_in,
  input  wire logic [15:0]               wdata_in,
  input  wire srxsh_pkg::srxsh_event_type evt_in,
  input  wire logic                      done_sync_in,
  output logic [15:0]                    count_out,
  output logic [15:0]                    code_out,
  output logic [15:0]                    result_out,
  output logic [15:0]                    act_count_out,
  output logic [15:0]                    act_code_out,
  output logic                           use_code_out,
  output logic                           req_out,
  output logic                           err_out
);
  import srxsh_pkg::*;
  logic [15:0]     count_reg, count_next, code_reg, code_next;
  logic [15:0]     result_reg, result_next, acount_reg, acount_next;
  logic [15:0]     acode_reg, acode_next;
  srxsh_state_type st_reg, st_next;
  logic            win;
  logic            req_reg, req_next, err_reg, err_next, use_reg, use_next;

  // Next state: settings, handshake, frame-boundary apply
  always_comb begin
    count_next  = count_reg;
    code_next   = code_reg;
    result_next = result_reg;
    acount_next = acount_reg;
    acode_next  = acode_reg;
    st_next     = st_reg;
    // Writes after start only land inside the handshake window
    win = (st_reg != SRXSH_IDLE) && !done_sync_in;
    if (wr_count_in && (!started_in || win)) begin
      count_next = wdata_in;
    end
    if (wr_code_in && (!started_in || win)) begin
      // Only single-byte codes or the none marker are accepted
      if (wdata_in <= CODE_MAX || wdata_in == CODE_NONE) begin
        code_next = wdata_in;
      end
    end
    case (st_reg)
      SRXSH_IDLE: begin
        if (evt_in.done && evt_in.error) begin
          st_next     = SRXSH_ERR;
          result_next = evt_in.code;
        end else if (evt_in.done) begin
          st_next     = SRXSH_REQ;
          result_next = RESULT_RESET;
        end
      end
      SRXSH_REQ, SRXSH_ERR: begin
        if (done_sync_in) begin
          st_next     = SRXSH_IDLE;
          acount_next = count_reg;
          acode_next  = code_reg;
        end
      end
      default: st_next = SRXSH_IDLE;
    endcase
    // Before start the engine follows the settings directly
    if (!started_in) begin
      acount_next = count_next;
      acode_next  = code_next;
    end
    // Flags and framing mode kept in flops so top outputs are glitch free
    req_next = (st_next == SRXSH_REQ);
    err_next = (st_next == SRXSH_ERR);
    use_next = (acode_next != CODE_NONE);
  end

  // State registers
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      count_reg  <= COUNT_RESET;
      code_reg   <= CODE_RESET;
      result_reg <= RESULT_RESET;
      acount_reg <= COUNT_RESET;
      acode_reg  <= CODE_RESET;
      st_reg     <= SRXSH_IDLE;
      req_reg    <= 1'b0;
      err_reg    <= 1'b0;
      use_reg    <= 1'b1;
    end else begin
      count_reg  <= count_next;
      code_reg   <= code_next;
      result_reg <= result_next;
      acount_reg <= acount_next;
      acode_reg  <= acode_next;
      st_reg     <= st_next;
      req_reg    <= req_next;
      err_reg    <= err_next;
      use_reg    <= use_next;
    end
  end

  assign count_out     = count_reg;
  assign code_out      = code_reg;
  assign result_out    = result_reg;
  assign act_count_out = acount_reg;
  assign act_code_out  = acode_reg;
  assign use_code_out  = use_reg;
  assign req_out       = req_reg;
  assign err_out       = err_reg;

  // Flags are mutually exclusive and only follow a frame event
  a_flags_exclusive: assert property (@(posedge clk_in) disable iff (rst_in)
    !(req_out && err_out)) else $error("request and error both high");
  a_req_cause: assert property (@(posedge clk_in) disable iff (rst_in)
    $rose(req_out) |-> $past(evt_in.done && !evt_in.error))
    else $error("request without normal frame");
  a_err_cause: assert property (@(posedge clk_in) disable iff (rst_in)
    $rose(err_out) |-> result_out == $past(evt_in.code))
    else $error("error code not recorded");
  a_done_clears: assert property (@(posedge clk_in) disable iff (rst_in)
    (req_out || err_out) && done_sync_in |=> !req_out && !err_out
    && act_count_out == $past(count_out)) else $error("done not honoured");
  a_locked_count: assert property (@(posedge clk_in) disable iff (rst_in)
    started_in && !req_out && !err_out |=> $stable(count_out))
    else $error("count changed outside window");
  a_code_range: assert property (@(posedge clk_in) disable iff (rst_in)
    code_out <= CODE_MAX || code_out == CODE_NONE || code_out == CODE_RESET)
    else $error("end code out of range");
endmodule : srxsh_chan

// ==========================================================
// Top: word register port, two channels, registered outputs
module srxsh_top (
  input  wire logic                       clk_in,
  input  wire logic                       rst_in,
  input  wire logic                       started_in,
  input  wire srxsh_pkg::srxsh_bus_type   bus_in,
  input  wire srxsh_pkg::srxsh_event_type evt_ch1_in,
  input  wire srxsh_pkg::srxsh_event_type evt_ch2_in,
  input  wire logic                       rx_read_done_ch1_in,
  input  wire logic                       rx_read_done_ch2_in,
  output logic [15:0]                     rdata_out,
  output logic                            rvalid_out,
  output logic                            rx_read_request_ch1_out,
  output logic                            rx_read_request_ch2_out,
  output logic                            rx_error_detect_ch1_out,
  output logic                            rx_error_detect_ch2_out,
  output logic [15:0]                     act_count_ch1_out,
  output logic [15:0]                     act_code_ch1_out,
  output logic [15:0]                     act_count_ch2_out,
  output logic [15:0]                     act_code_ch2_out,
  output logic                            use_code_ch1_out,
  output logic                            use_code_ch2_out
);
  import srxsh_pkg::*;
  logic [1:0]  done_meta_reg, done_sync_reg;
  logic [15:0] cnt1, cod1, res1, cnt2, cod2, res2;
  logic [15:0] rdata_reg, rdata_next;
  logic        rvalid_reg;

  // Done pins come from the host domain: two-stage sync
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      done_meta_reg <= 2'b00;
      done_sync_reg <= 2'b00;
    end else begin
      done_meta_reg <= {rx_read_done_ch2_in, rx_read_done_ch1_in};
      done_sync_reg <= done_meta_reg;
    end
  end

  // Two independent channel instances
  srxsh_chan u_ch1 (.clk_in(clk_in), .rst_in(rst_in), .started_in(started_in),
    .wr_count_in(bus_in.wr && bus_in.addr == ADDR_COUNT_CH1),
    .wr_code_in(bus_in.wr && bus_in.addr == ADDR_CODE_CH1),
    .wdata_in(bus_in.wdata), .evt_in(evt_ch1_in), .done_sync_in(done_sync_reg[0]),
    .count_out(cnt1), .code_out(cod1), .result_out(res1),
    .act_count_out(act_count_ch1_out), .act_code_out(act_code_ch1_out),
    .use_code_out(use_code_ch1_out), .req_out(rx_read_request_ch1_out),
    .err_out(rx_error_detect_ch1_out));
  srxsh_chan u_ch2 (.clk_in(clk_in), .rst_in(rst_in), .started_in(started_in),
    .wr_count_in(bus_in.wr && bus_in.addr == ADDR_COUNT_CH2),
    .wr_code_in(bus_in.wr && bus_in.addr == ADDR_CODE_CH2),
    .wdata_in(bus_in.wdata), .evt_in(evt_ch2_in), .done_sync_in(done_sync_reg[1]),
    .count_out(cnt2), .code_out(cod2), .result_out(res2),
    .act_count_out(act_count_ch2_out), .act_code_out(act_code_ch2_out),
    .use_code_out(use_code_ch2_out), .req_out(rx_read_request_ch2_out),
    .err_out(rx_error_detect_ch2_out));

  // Read decode; unmapped words read as zero
  always_comb begin
    case (bus_in.addr)
      ADDR_COUNT_CH1:  rdata_next = cnt1;
      ADDR_CODE_CH1:   rdata_next = cod1;
      ADDR_COUNT_CH2:  rdata_next = cnt2;
      ADDR_CODE_CH2:   rdata_next = cod2;
      ADDR_RESULT_CH1: rdata_next = res1;
      ADDR_RESULT_CH2: rdata_next = res2;
      default:         rdata_next = 16'h0000;
    endcase
  end

  // Read data registered one cycle after the strobe
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_reg  <= 16'h0000;
      rvalid_reg <= 1'b0;
    end else begin
      rdata_reg  <= bus_in.rd ? rdata_next : rdata_reg;
      rvalid_reg <= bus_in.rd;
    end
  end
  assign rdata_out  = rdata_reg;
  assign rvalid_out = rvalid_reg;

  a_read_latency: assert property (@(posedge clk_in) disable iff (rst_in)
    bus_in.rd && bus_in.addr == ADDR_RESULT_CH1 |=> rvalid_out && rdata_out == $past(res1))
    else $error("result read wrong");
  a_chan_indep: assert property (@(posedge clk_in) disable iff (rst_in)
    bus_in.wr && bus_in.addr == ADDR_COUNT_CH1 |=> $stable(cnt2))
    else $error("channel crosstalk");
endmodule : srxsh_top

// ### tb/srxsh_host_model.sv
// Host controller model: answers receive flags with read completion
`timescale 1ns/1ps

module srxsh_host_model #(
  parameter int DELAY = 4
) (
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic flag_in,
  output logic      done_out
);
  int cnt_reg;
  // ==========================================================
  // Flag handling
  // Hold completion low long enough for the bench to read and rewrite
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_reg  <= 0;
      done_out <= 1'b0;
    end else if (!flag_in) begin
      cnt_reg  <= 0;
      done_out <= 1'b0;
    end else if (cnt_reg < DELAY) begin
      cnt_reg <= cnt_reg + 1; // Rewrite window stays open
    end else begin
      done_out <= 1'b1; // Only after reads and rewrites
    end
  end
endmodule : srxsh_host_model

// ### tb/tb_top.sv
// Testbench for the receive setting handshake block
`timescale 1ns/1ps

module tb_top;
  import srxsh_pkg::*;
  logic            clk_in, rst_in, started_in, rvalid, d1, d2;
  logic            q1, q2, e1, e2, u1, u2;
  logic [15:0]     rdata, ac1, ak1, ac2, ak2;
  srxsh_bus_type   bus_in;
  srxsh_event_type ev1, ev2;
  int              error_cnt = 0;
  int              comparisons = 0;

  srxsh_top u_dut (.clk_in(clk_in), .rst_in(rst_in), .started_in(started_in),
    .bus_in(bus_in), .evt_ch1_in(ev1), .evt_ch2_in(ev2), .rx_read_done_ch1_in(d1),
    .rx_read_done_ch2_in(d2), .rdata_out(rdata), .rvalid_out(rvalid),
    .rx_read_request_ch1_out(q1), .rx_read_request_ch2_out(q2),
    .rx_error_detect_ch1_out(e1), .rx_error_detect_ch2_out(e2),
    .act_count_ch1_out(ac1), .act_code_ch1_out(ak1), .act_count_ch2_out(ac2),
    .act_code_ch2_out(ak2), .use_code_ch1_out(u1), .use_code_ch2_out(u2));
  // Slow host on one channel, prompt host on the other
  srxsh_host_model #(.DELAY(20)) u_host1 (.clk_in(clk_in), .rst_in(rst_in),
    .flag_in(q1 | e1), .done_out(d1));
  srxsh_host_model #(.DELAY(12)) u_host2 (.clk_in(clk_in), .rst_in(rst_in),
    .flag_in(q2 | e2), .done_out(d2));

  // ==========================================================
  // Clock and watchdog
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  // Whole run needs well under a thousand cycles
  initial begin
    #20000;
    error_cnt++;
    tally_and_finish();
  end

  // ==========================================================
  // Compare, bus and event tasks
  task chk(input string n, input logic [15:0] x, input logic [15:0] g);
    comparisons++;
    if (g !== x) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", n, x, g);
    end
  endtask : chk
  task chkb(input string n, input logic x, input logic g);
    comparisons++;
    if (g !== x) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %b seen %b", n, x, g);
    end
  endtask : chkb
  task wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk_in);
    bus_in <= '{1'b1, 1'b0, a, d};
    @(posedge clk_in);
    bus_in <= '0;
  endtask : wr
  // Valid stands for one cycle, so it is sampled just after it lands
  task rdchk(input logic [15:0] a, input logic [15:0] x);
    @(posedge clk_in);
    bus_in <= '{1'b0, 1'b1, a, 16'h0000};
    @(posedge clk_in);
    bus_in <= '0;
    #1;
    chkb("rvalid", 1'b1, rvalid);
    chk("rdata", x, rdata);
  endtask : rdchk
  task ev(input logic ch2, input logic err, input logic [15:0] code);
    @(posedge clk_in);
    if (ch2) ev2 <= '{1'b1, err, code};
    else ev1 <= '{1'b1, err, code};
    @(posedge clk_in);
    ev1 <= '0;
    ev2 <= '0;
    @(posedge clk_in);
    #1;
  endtask : ev
  task wait_low(input logic ch2);
    int n;
    n = 0;
    while ((ch2 ? (q2 | e2) : (q1 | e1)) !== 1'b0 && n < 60) begin
      @(posedge clk_in);
      n++;
    end
    #1;
    chkb("flag clear", 1'b0, ch2 ? (q2 | e2) : (q1 | e1));
  endtask : wait_low
  task tally_and_finish();
    $display("mismatches %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : tally_and_finish

  // ==========================================================
  // Main sequence
  initial begin
    rst_in = 1'b1;
    started_in = 1'b0;
    bus_in = '0;
    ev1 = '0;
    ev2 = '0;
    repeat (16) @(posedge clk_in);
    rst_in <= 1'b0;
    rdchk(ADDR_COUNT_CH1, COUNT_RESET);
    rdchk(ADDR_COUNT_CH2, COUNT_RESET);
    rdchk(ADDR_CODE_CH1, CODE_RESET);
    rdchk(ADDR_CODE_CH2, CODE_RESET);
    rdchk(ADDR_RESULT_CH2, RESULT_RESET);
    rdchk(16'h0300, 16'h0000);
    chkb("use code", 1'b1, u1);
    wr(ADDR_CODE_CH1, CODE_MAX);
    wr(ADDR_CODE_CH1, 16'h0100);
    wr(ADDR_RESULT_CH1, 16'h1234);
    wr(ADDR_CODE_CH2, CODE_NONE);
    rdchk(ADDR_CODE_CH1, CODE_MAX);
    rdchk(ADDR_RESULT_CH1, RESULT_RESET);
    chk("act code", CODE_NONE, ak2);
    chkb("use code", 1'b0, u2);
    chk("act code", CODE_MAX, ak1);
    @(posedge clk_in);
    started_in <= 1'b1;
    wr(ADDR_COUNT_CH1, 16'h0020);
    rdchk(ADDR_COUNT_CH1, COUNT_RESET);
    ev(1'b0, 1'b0, 16'h0000);
    chkb("request", 1'b1, q1);
    chkb("error", 1'b0, e1);
    chkb("other request", 1'b0, q2);
    wr(ADDR_COUNT_CH1, 16'h0020);
    wr(ADDR_CODE_CH1, CODE_NONE);
    chk("act count", COUNT_RESET, ac1);
    wait_low(1'b0);
    chk("act count", 16'h0020, ac1);
    chkb("use code", 1'b0, u1);
    ev(1'b1, 1'b1, 16'h7a51);
    chkb("error", 1'b1, e2);
    chkb("request", 1'b0, q2);
    rdchk(ADDR_RESULT_CH2, 16'h7a51);
    rdchk(ADDR_RESULT_CH1, RESULT_RESET);
    wait_low(1'b1);
    chk("act count", COUNT_RESET, ac2);
    chk("act code", CODE_NONE, ak2);
    tally_and_finish();
  end
endmodule : tb_top
